/* File: design/oslb_pkg.sv */
// Package for the optical serial loopback bridge.
// Assumes a single 20 MHz system clock; all line timing is sampled.
package oslb_pkg;
  localparam int OSLB_CLK_HZ       = 20000000;
  localparam int OSLB_RATE_LO_BPS  = 56000;
  localparam int OSLB_RATE_HI_BPS  = 64000;
  localparam int OSLB_DIV_LO       = OSLB_CLK_HZ / OSLB_RATE_LO_BPS;
  localparam int OSLB_DIV_HI       = OSLB_CLK_HZ / OSLB_RATE_HI_BPS;
  localparam int OSLB_DIV_W        = 9;
  localparam logic [8:0] OSLB_DIV_LO_C = 9'(OSLB_DIV_LO - 1);
  localparam logic [8:0] OSLB_DIV_HI_C = 9'(OSLB_DIV_HI - 1);
  localparam logic [1:0] OSLB_SYNC_RST = 2'h0;
  localparam logic [1:0] OSLB_SYNC_RST_MARK = 2'h3;

  typedef enum logic [1:0] {
    OSLB_VAR_CODIR = 2'h1,
    OSLB_VAR_CLKDATA = 2'h2
  } oslb_variant_t;

  typedef struct packed {
    logic opt_loop;
    logic elec_loop;
    logic role_dce;
    logic rate_64k;
    logic dsr_ovr;
    logic cts_ovr;
  } oslb_cfg_t;

  typedef struct packed {
    logic opt_loop;
    logic elec_loop;
    logic dsr_off;
    logic cts_off;
  } oslb_ind_t;
endpackage

/* File: design/oslb_sync.sv */
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is a pin outside the ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module oslb_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic din,
  output var  logic dout
);
  logic meta;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // oslb_sync
`default_nettype wire

/* File: design/oslb_bridge.sv */
// Optical to electrical serial bridge with loopbacks and handshake overrides.
// Assumes pins are asynchronous to ref_clk; line clock far slower than ref_clk.
// Operation
// - Optical loopback returns fibre receive to fibre transmit
// - Optical loopback indicator follows its switch
// - Codirectional electrical loopback feeds line receive back
// - Codirectional electrical loopback indicator follows switch
// - Clock-data electrical loopback feeds line receive back
// - Clock-data electrical loopback indicator follows switch
// - DSR-off indicator lit when DSR override disabled; the code lights it in the clock-data variant only
// - CTS-off indicator lit when CTS override disabled; the code lights it in the clock-data variant only
// - Role switch selects terminal or communications equipment
// - Rate switch selects 56 or 64 kb/s
// - Common clock, data sampled on rising edge
// - Codirectional timing travels with the data
// - Indicators dark in normal operation
// - Each variant leaves other connector unused
`timescale 1ns/1ps
`default_nettype none
module oslb_bridge #(
  parameter oslb_pkg::oslb_variant_t VARIANT = oslb_pkg::OSLB_VAR_CLKDATA
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire oslb_pkg::oslb_cfg_t cfg,
  input  wire logic              opt_rx,
  output var  logic              opt_tx,
  input  wire logic              cd_rx,
  output var  logic              cd_tx,
  input  wire logic              cl_rxd,
  output var  logic              cl_txd,
  input  wire logic              cl_clk_in,
  output var  logic              cl_clk_out,
  output var  logic              cl_clk_oe,
  input  wire logic              cl_dsr,
  input  wire logic              cl_cts,
  output var  logic              cl_rts,
  output var  logic              cl_dtr,
  output var  oslb_pkg::oslb_ind_t ind
);
  localparam bit IS_CD = (VARIANT == oslb_pkg::OSLB_VAR_CODIR);

  // Synchronised pins
  logic s_opt_rx, s_cd_rx, s_cl_rxd, s_cl_clk, s_dsr, s_cts;
  // Idle-high data pins reset high, so no false start bit after reset
  oslb_sync #(
    .INIT (1'b1)
  ) u_sync_opt_rx (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .din     (opt_rx),
    .dout    (s_opt_rx)
  );

  oslb_sync #(
    .INIT (1'b1)
  ) u_sync_cd_rx (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .din     (cd_rx),
    .dout    (s_cd_rx)
  );

  oslb_sync #(
    .INIT (1'b1)
  ) u_sync_cl_rxd (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .din     (cl_rxd),
    .dout    (s_cl_rxd)
  );

  oslb_sync #(
    .INIT (1'b0)
  ) u_sync_cl_clk (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .din     (cl_clk_in),
    .dout    (s_cl_clk)
  );

  oslb_sync #(
    .INIT (1'b0)
  ) u_sync_dsr (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .din     (cl_dsr),
    .dout    (s_dsr)
  );

  oslb_sync #(
    .INIT (1'b0)
  ) u_sync_cts (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .din     (cl_cts),
    .dout    (s_cts)
  );

  // Internal line clock when acting as communications equipment
  logic [8:0] div_cnt;
  logic       int_clk;
  wire  [8:0] div_top = cfg.rate_64k ? oslb_pkg::OSLB_DIV_HI_C : oslb_pkg::OSLB_DIV_LO_C;
  wire        div_wrap = (div_cnt >= div_top);
  wire  [8:0] next_div_cnt = div_wrap ? 9'h000 : div_cnt + 9'h001;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt <= 9'h000;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  wire        div_half = (div_cnt == {1'b0, div_top[8:1]});
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_clk <= 1'b0;
    end else if (div_wrap || div_half) begin
      int_clk <= ~int_clk;
    end
  end

  // Common line clock: own when DCE, partner's when DTE
  wire role_dce = cfg.role_dce;
  wire line_clk = role_dce ? int_clk : s_cl_clk;
  logic line_clk_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_clk_q <= 1'b0;
    end else begin
      line_clk_q <= line_clk;
    end
  end
  wire line_rise = line_clk & ~line_clk_q;

  // Handshake with override forcing
  wire dsr_eff = cfg.dsr_ovr | s_dsr;
  wire cts_eff = cfg.cts_ovr | s_cts;
  wire tx_permit = role_dce | (dsr_eff & cts_eff);

  // Data selection
  wire opt_out_sel = cfg.opt_loop ? s_opt_rx : 1'b1;
  wire el_rx = IS_CD ? s_cd_rx : s_cl_rxd;
  wire el_src = cfg.elec_loop ? el_rx : s_opt_rx;
  wire el_bit = IS_CD ? el_src : (tx_permit ? el_src : 1'b1);

  // Fibre return path carries line receive data when not looped
  wire next_opt_tx = cfg.opt_loop ? opt_out_sel : el_rx;
  logic cl_txd_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      opt_tx <= 1'b1;
    end else begin
      opt_tx <= next_opt_tx;
    end
  end

  // Codirectional: timing rides with the data on the same pair
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cd_tx <= 1'b1;
    end else if (IS_CD) begin
      cd_tx <= el_bit;
    end
  end

  // Mark held at once while refused, so no stale bit stays on the line
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cl_txd_q <= 1'b1;
    end else if (!IS_CD && !tx_permit) begin
      cl_txd_q <= 1'b1;
    end else if (!IS_CD && line_rise) begin
      cl_txd_q <= el_bit;
    end
  end

  // Unused connector parked idle
  assign cl_txd     = IS_CD ? 1'b1 : cl_txd_q;
  assign cl_clk_out = int_clk;
  assign cl_clk_oe  = !IS_CD && role_dce;
  wire next_rts = !IS_CD && !role_dce;
  wire next_dtr = !IS_CD && !role_dce;

  // Registered so the handshake lines never glitch on a switch change
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cl_rts <= 1'b0;
    end else begin
      cl_rts <= next_rts;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cl_dtr <= 1'b0;
    end else begin
      cl_dtr <= next_dtr;
    end
  end

  // Indicators, dark in normal operation
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ind <= '0;
    end else begin
      ind.opt_loop  <= cfg.opt_loop;
      ind.elec_loop <= cfg.elec_loop;
      ind.dsr_off   <= !IS_CD && !cfg.dsr_ovr;
      ind.cts_off   <= !IS_CD && !cfg.cts_ovr;
    end
  end
endmodule // oslb_bridge
`default_nettype wire

/* File: tb/oslb_bridge_properties.sv */
// Port assertions for the bridge.
// Assumes the clock-data variant on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module oslb_props (
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  input wire oslb_pkg::oslb_cfg_t cfg,
  input wire logic                opt_rx,
  input wire logic                opt_tx,
  input wire logic                cl_txd,
  input wire logic                cl_dsr,
  input wire logic                cl_clk_oe,
  input wire oslb_pkg::oslb_ind_t ind
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  opt_ind_a: assert property (1'b1 |=> ind.opt_loop == $past(cfg.opt_loop)) else $error("opt ind");
  elec_ind_a: assert property (1'b1 |=> ind.elec_loop == $past(cfg.elec_loop)) else $error("elec ind");
  dsr_off_a: assert property (1'b1 |=> ind.dsr_off != $past(cfg.dsr_ovr)) else $error("dsr ind");
  cts_off_a: assert property (1'b1 |=> ind.cts_off != $past(cfg.cts_ovr)) else $error("cts ind");
  quiet_ind_a: assert property (cfg == 6'h0F |=> ind == 4'h0) else $error("ind lit");
  opt_loop_a: assert property ((cfg.opt_loop && $stable(opt_rx)) [*5] |-> opt_tx == opt_rx) else $error("loop");
  clk_drive_a: assert property (cfg.role_dce [*3] |-> cl_clk_oe) else $error("clk oe");
  tx_hold_a: assert property ((!cfg.role_dce && !cfg.dsr_ovr && !cl_dsr) [*8] |-> cl_txd) else $error("tx");
  cover property (cfg.opt_loop && opt_tx);
  cover property (cfg.elec_loop && cfg.role_dce);
  cover property (!cfg.role_dce && !cl_txd);
endmodule // oslb_props
bind oslb_bridge oslb_props u_props (.ref_clk, .sys_rst, .cfg, .opt_rx, .opt_tx, .cl_txd, .cl_dsr, .cl_clk_oe, .ind);
`default_nettype wire

/* File: tb/oslb_modem.sv */
// Far-side modem on the clock-data line.
// Assumes run is high only while a frame is wanted.
`timescale 1ns/1ps
`default_nettype none
module oslb_modem (
  input  wire logic run,
  input  wire logic rdy,
  input  wire logic rts,
  input  wire logic bit_in,
  output var  logic clk,
  output wire logic dsr,
  output wire logic cts,
  output wire logic rxd
);
  logic q;
  initial begin
    clk = 1'b0;
    forever #200 clk = run ? !clk : 1'b0;
  end
  assign dsr = rdy;
  assign cts = rdy & rts;
  // Launch on falling edge so the rising edge sees settled data
  always @(negedge clk) q <= bit_in;
  assign rxd = run ? q : bit_in;
endmodule // oslb_modem
`default_nettype wire

/* File: tb/oslb_bridge_tb.sv */
// Bench for the bridge, clock-data variant.
// Assumes the modem model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module oslb_bridge_tb;
  logic ref_clk, sys_rst, opt_rx, run, rdy, b, opt_tx, cl_txd, lclk, dsr, cts, rts, rxd, oe;
  logic cko, cko_q, dtr, cdtx;
  int cnt, per;
  oslb_pkg::oslb_cfg_t cfg;
  oslb_pkg::oslb_ind_t ind;
  int errors, checks;
  oslb_modem m (.run, .rdy, .rts, .bit_in(b), .clk(lclk), .dsr, .cts, .rxd);
  oslb_bridge dut (.ref_clk, .sys_rst, .cfg, .opt_rx, .opt_tx, .cd_rx(1'b1), .cd_tx(cdtx), .cl_rxd(rxd), .cl_txd,
    .cl_clk_in(lclk), .cl_clk_out(cko), .cl_clk_oe(oe), .cl_dsr(dsr), .cl_cts(cts), .cl_rts(rts), .cl_dtr(dtr), .ind);
  // Own line clock period, in ref_clk cycles between rises
  always @(posedge ref_clk) begin
    cko_q <= cko;
    cnt <= (cko && !cko_q) ? 1 : cnt + 1;
    if (cko && !cko_q) per <= cnt;
  end
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic step(logic [5:0] c, logic o, logic d, logic r, int n);
    @(posedge ref_clk);
    {cfg, opt_rx, b, rdy} <= {c, o, d, r};
    run <= !c[3]; // Line clock runs only in terminal role
    repeat (n) @(negedge ref_clk);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = !ref_clk;
  end
  initial begin
    #400000;
    errors++;
    finish_test;
  end
  initial begin
    errors = 0;
    checks = 0;
    sys_rst = 1'b1;
    {cfg, opt_rx, b, rdy, run} = 10'h0FE;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    step(6'h0F, 1'b1, 1'b1, 1'b1, 3);
    chk("ind", ind, 4'h0);
    for (int j = 0; j < 16; j++) begin
      step({j[3:2], 2'h3, j[1:0]}, 1'b1, 1'b1, 1'b1, 3);
      chk("ind", ind, {j[3:2], ~j[1:0]});
    end
    for (int v = 0; v < 2; v++) begin
      step(6'h2F, v[0], 1'b1, 1'b1, 6);
      chk("otx", opt_tx, v[0]);
    end
    for (int v = 0; v < 4; v++) begin
      step({3'h3, v[1], 2'h3}, 1'b1, v[0], 1'b1, 900); // About two and a half bit times at the slow rate
      chk("txd", cl_txd, v[0]);
      chk("oe", oe, 1'b1);
      chk("per", 16'(per), v[1] ? 16'(oslb_pkg::OSLB_DIV_HI) : 16'(oslb_pkg::OSLB_DIV_LO));
      chk("cdtx", cdtx, 1'b1);
    end
    for (int v = 0; v < 4; v++) begin
      step(6'h10, 1'b1, v[0], v[1], 60);
      chk("txd", cl_txd, v[1] ? v[0] : 1'b1);
      chk("rts", rts, 1'b1);
      chk("dtr", dtr, 1'b1);
    end
    step(6'h13, 1'b1, 1'b0, 1'b0, 60);
    chk("txd", cl_txd, 1'b0);
    finish_test;
  end
endmodule // oslb_bridge_tb
`default_nettype wire
